// File: logic/pmp_pkg.sv
package pmp_pkg;

  // ==========================================================================
  // Management frame fields.
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] BCAST_PHY_ADDR = 5'h00;
  localparam logic [4:0] OP_LAST = 5'h01;
  localparam logic [4:0] ADDR_LAST = 5'h09;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [4:0] SKIP_LAST = 5'h11;
  localparam int unsigned REG_DATA_W = 16;
  localparam int unsigned REG_COUNT = 32;

  // ==========================================================================
  // Management register indices and field positions.
  localparam logic [4:0] IDX_CTRL = 5'h1f;
  localparam logic [4:0] IDX_INT_EN = 5'h1b;
  localparam logic [4:0] IDX_INT_STAT = 5'h1c;
  localparam int unsigned CTRL_BCAST_BIT = 0;
  localparam int unsigned CTRL_MDIO_PP_BIT = 1;
  localparam int unsigned CTRL_INT_PP_BIT = 2;
  localparam int unsigned CTRL_INT_INV_BIT = 3;
  localparam int unsigned INT_EVT_W = 15;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // The strap is taken only once the pin synchroniser has refilled after reset.
  localparam logic [1:0] STRAP_LOAD = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;

  // ==========================================================================
  // Wishbone map and bus event bits.
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned WB_ARRAY_SEL_BIT = 7;
  localparam logic [7:0] WB_EVT_STATUS = 8'h80;
  localparam logic [7:0] WB_EVT_MASK = 8'h84;
  localparam int unsigned WB_EVT_W = 3;
  localparam int unsigned EVT_WRITE_BIT = 0;
  localparam int unsigned EVT_READ_BIT = 1;
  localparam int unsigned EVT_IGNORE_BIT = 2;

  // ==========================================================================
  // Frame decoder states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_OP,
    ST_ADDR,
    ST_TA,
    ST_DATA,
    ST_SKIP
  } pmp_state_t;

endpackage

// File: logic/pmp_sync.sv
`timescale 1ns/1ps

// ============================================================================
// Two flip-flop synchroniser for pins from outside the clock domain.
module pmp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  if (WIDTH < 1) begin : g_chk
    $error("pmp_sync needs a width of at least one.");
  end

  // The first stage feeds the second stage only.
  always_comb begin
    next_stage1 = async_i;
    next_sync = stage1;
  end

  // Both stages clear on reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_o <= next_sync;
    end
  end

endmodule

// File: logic/pmp_top.sv
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

// What this block does
// R1 - Frame: preamble, start, opcode, addresses, turnaround, data.
// R2 - Answer at strapped five-bit address.
// R3 - Decode five-bit index into thirty-two registers.
// R4 - Controller keeps long-format devices off bus.
// R5 - Data line is open-drain after reset.
// R6 - Controller switches to push-pull before fast clock.
// R7 - Drive-type bit: zero open-drain, one push-pull.
// R8 - Broadcast enable also accepts address zero, for writes only.
// R9 - Broadcast enable resets from strap input.
// R10 - Interrupt output only for enabled conditions.
// R11 - Status bits set regardless of enables.
// R12 - Status clears on read; summary follows source.
// R13 - Interrupt drive type selectable, open-drain default.
// R14 - Invert bit picks polarity, active low default.
// R15 - Open-drain interrupt is always active low.
// R16 - Foreign addresses ignored, data line released.
// R17 - Sample on rising clock; read drives zero, MSB first.
module pmp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pmp_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic [4:0] strapped_phy_address_i,
  input wire logic broadcast_address_strap_i,
  input wire logic [pmp_pkg::INT_EVT_W-1:0] event_i,
  input wire logic summary_i,
  output logic int_o,
  output logic int_oe_o
);

  // ==========================================================================
  // Pin synchronisers.
  logic [7:0] pins_s;
  logic mdc_s;
  logic mdio_s;
  logic strap_s;
  logic [4:0] phy_addr_s;
  logic mdc_d;
  logic mdc_rise;

  pmp_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({mdc_i, mdio_i, broadcast_address_strap_i, strapped_phy_address_i}),
    .sync_o(pins_s)
  );

  // Synchronised pins split back into their meanings.
  assign mdc_s = pins_s[7];
  assign mdio_s = pins_s[6];
  assign strap_s = pins_s[5];
  assign phy_addr_s = pins_s[4:0];
  assign mdc_rise = mdc_s & ~mdc_d;

  // ==========================================================================
  // Register storage and read decode.
  logic [15:0] regs [pmp_pkg::REG_COUNT];
  logic [pmp_pkg::INT_EVT_W-1:0] int_stat;
  logic [1:0] strap_wait;
  logic bcast_en;
  logic mdio_pp;
  logic int_pp;
  logic int_inv;
  logic int_active;

  // Status reads return the live summary source on top of the latched bits.
  function automatic logic [15:0] rd_value(input logic [4:0] idx);
    if (idx == pmp_pkg::IDX_INT_STAT) begin
      rd_value = {summary_i, int_stat}; // [R12]
    end else begin
      rd_value = regs[idx]; // [R3]
    end
  endfunction

  // Control bits taken from the common control register.
  assign bcast_en = regs[pmp_pkg::IDX_CTRL][pmp_pkg::CTRL_BCAST_BIT];
  assign mdio_pp = regs[pmp_pkg::IDX_CTRL][pmp_pkg::CTRL_MDIO_PP_BIT];
  assign int_pp = regs[pmp_pkg::IDX_CTRL][pmp_pkg::CTRL_INT_PP_BIT];
  assign int_inv = regs[pmp_pkg::IDX_CTRL][pmp_pkg::CTRL_INT_INV_BIT];

  // A process, not an assign, so that status changes inside the function still reach the pin.
  always_comb begin
    int_active = |(rd_value(pmp_pkg::IDX_INT_STAT) & regs[pmp_pkg::IDX_INT_EN]); // [R10]
  end

  // ==========================================================================
  // Management frame decoder.
  pmp_pkg::pmp_state_t state;
  pmp_pkg::pmp_state_t next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [5:0] pre_cnt;
  logic [5:0] next_pre_cnt;
  logic [9:0] hdr;
  logic [9:0] next_hdr;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic is_read;
  logic next_is_read;
  logic drive_en;
  logic next_drive_en;
  logic drive_bit;
  logic next_drive_bit;
  logic mdio_we;
  logic rd_cap;
  logic ev_ign;
  logic [9:0] hdr_in;
  logic [15:0] rd_word;
  logic addr_own;
  logic addr_bcast;

  // Header bits as they stand once the current bit is shifted in.
  assign hdr_in = {hdr[8:0], mdio_s};
  assign addr_own = (hdr_in[9:5] == phy_addr_s); // [R2]
  assign addr_bcast = bcast_en && (hdr_in[9:5] == pmp_pkg::BCAST_PHY_ADDR); // [R8]

  // The read word follows the register contents as well as the index.
  always_comb begin
    rd_word = rd_value(hdr[4:0]);
  end

  // Bits are taken at each rising management clock edge.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pre_cnt = pre_cnt;
    next_hdr = hdr;
    next_shift = shift;
    next_is_read = is_read;
    next_drive_en = drive_en;
    next_drive_bit = drive_bit;
    mdio_we = 1'b0;
    rd_cap = 1'b0;
    ev_ign = 1'b0;
    if (mdc_rise) begin // [R17]
      unique case (state)
        pmp_pkg::ST_IDLE: begin
          if (mdio_s) begin
            if (pre_cnt != pmp_pkg::PREAMBLE_ONES) begin
              next_pre_cnt = pre_cnt + 6'h01;
            end
          end else begin
            next_pre_cnt = 6'h00;
            if (pre_cnt == pmp_pkg::PREAMBLE_ONES) begin // [R1]
              next_state = pmp_pkg::ST_START;
            end
          end
        end
        pmp_pkg::ST_START: begin
          next_cnt = 5'h00;
          next_state = mdio_s ? pmp_pkg::ST_OP : pmp_pkg::ST_IDLE;
        end
        pmp_pkg::ST_OP: begin
          next_hdr = hdr_in;
          next_cnt = cnt + 5'h01;
          if (cnt == pmp_pkg::OP_LAST) begin
            next_cnt = 5'h00;
            next_is_read = (hdr_in[1:0] == pmp_pkg::OP_READ);
            if ((hdr_in[1:0] == pmp_pkg::OP_READ) || (hdr_in[1:0] == pmp_pkg::OP_WRITE)) begin
              next_state = pmp_pkg::ST_ADDR;
            end else begin
              next_state = pmp_pkg::ST_IDLE;
              ev_ign = 1'b1;
            end
          end
        end
        pmp_pkg::ST_ADDR: begin
          next_hdr = hdr_in;
          next_cnt = cnt + 5'h01;
          if (cnt == pmp_pkg::ADDR_LAST) begin
            next_cnt = 5'h00;
            if (addr_own || (addr_bcast && !is_read)) begin
              next_state = pmp_pkg::ST_TA;
            end else begin
              next_state = pmp_pkg::ST_SKIP; // [R16]
              ev_ign = 1'b1;
            end
          end
        end
        pmp_pkg::ST_TA: begin
          next_cnt = cnt + 5'h01;
          if (cnt != pmp_pkg::TA_LAST) begin
            next_drive_en = is_read;
            next_drive_bit = 1'b0; // [R17]
          end else begin
            next_cnt = 5'h00;
            next_state = pmp_pkg::ST_DATA;
            if (is_read) begin
              next_shift = rd_word;
              next_drive_bit = rd_word[15];
              rd_cap = 1'b1;
            end
          end
        end
        pmp_pkg::ST_DATA: begin
          next_cnt = cnt + 5'h01;
          if (is_read) begin
            next_shift = {shift[14:0], 1'b0};
            next_drive_bit = shift[14]; // [R17]
          end else begin
            next_shift = {shift[14:0], mdio_s};
          end
          if (cnt == pmp_pkg::DATA_LAST) begin
            next_state = pmp_pkg::ST_IDLE;
            next_drive_en = 1'b0;
            mdio_we = !is_read;
          end
        end
        pmp_pkg::ST_SKIP: begin
          next_cnt = cnt + 5'h01;
          if (cnt == pmp_pkg::SKIP_LAST) begin
            next_state = pmp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Frame decoder registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= pmp_pkg::ST_IDLE;
      cnt <= 5'h00;
      pre_cnt <= 6'h00;
      hdr <= 10'h000;
      shift <= 16'h0000;
      is_read <= 1'b0;
      drive_en <= 1'b0;
      drive_bit <= 1'b0;
      mdc_d <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pre_cnt <= next_pre_cnt;
      hdr <= next_hdr;
      shift <= next_shift;
      is_read <= next_is_read;
      drive_en <= next_drive_en;
      drive_bit <= next_drive_bit;
      mdc_d <= mdc_s;
    end
  end

  // Open-drain releases the line for ones; push-pull drives both levels.
  assign mdio_oe_o = mdio_pp ? drive_en : (drive_en & ~drive_bit); // [R7]
  assign mdio_o = mdio_pp & drive_bit; // [R5]

  // ==========================================================================
  // Interrupt status and pin.
  logic [pmp_pkg::INT_EVT_W-1:0] next_int_stat;
  logic stat_clr;

  assign stat_clr = rd_cap && (hdr[4:0] == pmp_pkg::IDX_INT_STAT);

  // Events set their bits whatever the enables; a new event beats the read clear.
  always_comb begin
    next_int_stat = int_stat;
    if (stat_clr) begin
      next_int_stat = '0; // [R12]
    end
    next_int_stat = next_int_stat | event_i; // [R11]
  end

  // Status register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat <= '0;
    end else begin
      int_stat <= next_int_stat;
    end
  end

  // Open-drain forces active low; push-pull follows the invert bit.
  always_comb begin
    if (int_pp) begin
      int_oe_o = 1'b1; // [R13]
      int_o = int_inv ? int_active : ~int_active; // [R14]
    end else begin
      int_oe_o = int_active; // [R15]
      int_o = 1'b0;
    end
  end

  // ==========================================================================
  // Wishbone slave with bus event flags.
  logic wb_req;
  logic wb_wr;
  logic wb_arr;
  logic [31:0] wb_rdata;
  logic [15:0] wb_bmask;
  logic [pmp_pkg::WB_EVT_W-1:0] evt;
  logic [pmp_pkg::WB_EVT_W-1:0] evt_mask;
  logic [pmp_pkg::WB_EVT_W-1:0] next_evt;
  logic [pmp_pkg::WB_EVT_W-1:0] next_evt_mask;
  logic [pmp_pkg::WB_EVT_W-1:0] evt_set;

  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & wb_ack_o;
  assign wb_arr = ~wb_adr_i[pmp_pkg::WB_ARRAY_SEL_BIT];
  assign wb_bmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign evt_set = {ev_ign, rd_cap, mdio_we};
  assign irq_o = |(evt & evt_mask);

  // Read mux; unmapped words read as zero.
  always_comb begin
    wb_rdata = 32'h0000_0000;
    if (wb_arr) begin
      wb_rdata = {16'h0000, rd_value(wb_adr_i[6:2])};
    end else if (wb_adr_i == pmp_pkg::WB_EVT_STATUS) begin
      wb_rdata = {29'h0000_0000, evt};
    end else if (wb_adr_i == pmp_pkg::WB_EVT_MASK) begin
      wb_rdata = {29'h0000_0000, evt_mask};
    end
  end

  // Event flags clear by writing ones, but a same-cycle event wins.
  always_comb begin
    next_evt = evt;
    next_evt_mask = evt_mask;
    if (wb_wr && wb_sel_i[0] && (wb_adr_i == pmp_pkg::WB_EVT_STATUS)) begin
      next_evt = evt & ~wb_dat_i[pmp_pkg::WB_EVT_W-1:0];
    end
    if (wb_wr && wb_sel_i[0] && (wb_adr_i == pmp_pkg::WB_EVT_MASK)) begin
      next_evt_mask = wb_dat_i[pmp_pkg::WB_EVT_W-1:0];
    end
    next_evt = next_evt | evt_set;
  end

  // Bus answer one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      evt <= '0;
      evt_mask <= '0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req && !wb_ack_o) begin
        wb_dat_o <= wb_rdata;
      end
      evt <= next_evt;
      evt_mask <= next_evt_mask;
    end
  end

  // Register array: frame writes win over bus writes; strap loads once the synchroniser has refilled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < pmp_pkg::REG_COUNT; i++) begin
        regs[i] <= pmp_pkg::REG_RESET; // [R5]
      end
      strap_wait <= 2'h0;
    end else begin
      if (strap_wait != pmp_pkg::STRAP_DONE) begin
        strap_wait <= strap_wait + 2'h1;
      end
      if (strap_wait == pmp_pkg::STRAP_LOAD) begin
        regs[pmp_pkg::IDX_CTRL][pmp_pkg::CTRL_BCAST_BIT] <= strap_s; // [R9]
      end
      if (mdio_we) begin
        regs[hdr[4:0]] <= next_shift; // [R3]
      end else if (wb_wr && wb_arr) begin
        regs[wb_adr_i[6:2]] <= (regs[wb_adr_i[6:2]] & ~wb_bmask) | (wb_dat_i[15:0] & wb_bmask);
      end
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_od_reset;
    $fell(rst_i) |-> !mdio_pp && !int_pp && !int_inv;
  endproperty
  a_od_reset: assert property (p_od_reset) else $error("Drive modes not default after reset."); // [R5]

  property p_mdio_od;
    !mdio_pp && mdio_oe_o |-> !mdio_o && drive_en && !drive_bit;
  endproperty
  a_mdio_od: assert property (p_mdio_od) else $error("Open-drain data line drove high."); // [R7]

  property p_int_od;
    !int_pp |-> !int_o && (int_oe_o == int_active);
  endproperty
  a_int_od: assert property (p_int_od) else $error("Open-drain interrupt not active low."); // [R15]

  property p_int_pp;
    int_pp |-> int_oe_o && (int_o == (int_inv ? int_active : !int_active));
  endproperty
  a_int_pp: assert property (p_int_pp) else $error("Push-pull interrupt level wrong."); // [R14]

  property p_int_gate;
    (regs[pmp_pkg::IDX_INT_EN] == 16'h0000) |-> !int_active;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("Interrupt raised with nothing enabled."); // [R10]

  property p_stat_set;
    (event_i != '0) |=> ((int_stat & $past(event_i)) == $past(event_i));
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("Event did not set its status bit."); // [R11]

  property p_strap;
    $fell(rst_i) |-> ##3 (bcast_en == $past(strap_s));
  endproperty
  a_strap: assert property (p_strap) else $error("Broadcast enable not loaded from strap."); // [R9]

  property p_skip_quiet;
    (state == pmp_pkg::ST_SKIP) |-> !mdio_oe_o && !drive_en;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("Line driven for foreign address."); // [R16]

  property p_ta_zero;
    mdc_rise && (state == pmp_pkg::ST_TA) && (cnt == 5'h00) && is_read |=> drive_en && !drive_bit [*2];
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("Turnaround zero not driven."); // [R17]

  property p_wb_ack;
    wb_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("Bus answer timing wrong.");

  c_read: cover property (rd_cap);
  c_write: cover property (mdio_we);
  c_bcast: cover property (mdio_we && bcast_en && (hdr[9:5] == pmp_pkg::BCAST_PHY_ADDR));
  c_irq: cover property ($rose(irq_o));

endmodule

// File: testbench/pmp_mdio_ctrl_model.sv
`timescale 1ns/1ps

// ====
// Station management controller that drives the clock line and sends frames.
module pmp_mdio_ctrl_model (
  input wire logic clk_i,
  input wire logic line_i,
  output logic mdc_o,
  output logic drv_o,
  output logic drv_oe_o,
  output logic done_o,
  output logic [16:0] rdata_o
);
  // The clock line rests low and the line is released between frames.
  initial begin
    mdc_o = 1'b0;
    drv_o = 1'b1;
    drv_oe_o = 1'b0;
    done_o = 1'b0;
    rdata_o = 17'h00000;
  end

  // One bit cell of 16 clocks, 12.5 MHz class, slow enough for either drive style.
  task automatic bit_cell(input logic oe, input logic v, output logic s);
    @(posedge clk_i);
    mdc_o <= 1'b0;
    drv_oe_o <= oe;
    drv_o <= v;
    repeat (8) @(posedge clk_i);
    s = line_i; // The line is sampled as the clock rises.
    mdc_o <= 1'b1;
    repeat (7) @(posedge clk_i);
  endtask

  // Only short-format frames are ever sent on this bus.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] idx,
                       input logic [15:0] wd);
    logic [45:0] hdr;
    logic [17:0] tail;
    logic [16:0] rd;
    logic s;
    hdr = {32'hffffffff, 2'b01, op, phy, idx};
    tail = {2'b10, wd};
    rd = 17'h00000;
    for (int i = 45; i >= 0; i--) begin
      bit_cell(1'b1, hdr[i], s);
    end
    for (int i = 17; i >= 0; i--) begin
      bit_cell(op == pmp_pkg::OP_WRITE, tail[i], s);
      if (i < 17) begin
        rd[i] = s;
      end
    end
    @(posedge clk_i);
    mdc_o <= 1'b0;
    drv_oe_o <= 1'b0;
    drv_o <= ~drv_o;
    if (op == pmp_pkg::OP_READ) begin
      done_o <= 1'b1;
      rdata_o <= rd;
      @(posedge clk_i);
      done_o <= 1'b0;
    end
  endtask
endmodule

// File: testbench/tb_phy_management_port_irq.sv
`timescale 1ns/1ps

// ====
// Bench for the management port: bus master, controller model and pins.
module tb_phy_management_port_irq;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, mdio_o, mdio_oe_o, int_o, int_oe_o;
  logic c_mdc, c_drv, c_oe, c_done;
  logic [16:0] c_rd;
  logic [4:0] phy_a = 5'h01;
  logic [14:0] event_i = 15'h0000;
  logic summary_i = 1'b0;
  logic bstrap = 1'b1;
  logic pp_seen = 1'b0;
  logic [31:0] exp_q[$];
  logic [15:0] d;
  logic [4:0] idx;
  integer seed;
  int failures = 0;
  int n_compared = 0;
  wire line = mdio_oe_o ? mdio_o : (c_oe ? c_drv : 1'b1); // Pull-up on the shared line.

  always #2.5 clk_i = ~clk_i;

  pmp_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'h3), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .mdc_i(c_mdc), .mdio_i(line), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
    .strapped_phy_address_i(phy_a), .broadcast_address_strap_i(bstrap), .event_i(event_i),
    .summary_i(summary_i), .int_o(int_o), .int_oe_o(int_oe_o));

  pmp_mdio_ctrl_model i_ctl (.clk_i(clk_i), .line_i(line), .mdc_o(c_mdc), .drv_o(c_drv),
    .drv_oe_o(c_oe), .done_o(c_done), .rdata_o(c_rd));

  // ====
  // Comparison, verdict and watchdog.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task final_report;
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    final_report;
  end

  // Results take the oldest expected note; a high driven one marks push-pull.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0) check("bus read", wb_dat_o, exp_q.pop_front());
    if (c_done === 1'b1) check("frame read", {15'h0000, c_rd}, exp_q.pop_front());
    if (mdio_oe_o === 1'b1 && mdio_o === 1'b1) pp_seen <= 1'b1;
  end

  // ====
  // Stimulus tasks.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h00000000);
  endtask

  task automatic mw(input logic [4:0] p, input logic [4:0] r, input logic [15:0] v);
    i_ctl.frame(pmp_pkg::OP_WRITE, p, r, v);
  endtask

  task automatic mr(input logic [4:0] p, input logic [4:0] r, input logic [31:0] e);
    exp_q.push_back(e);
    i_ctl.frame(pmp_pkg::OP_READ, p, r, 16'h0000);
  endtask

  task automatic evt(input int k);
    @(posedge clk_i);
    event_i <= 15'h0001 << k;
    @(posedge clk_i);
    event_i <= 15'h0000;
  endtask

  task automatic int_chk(input logic oe, input logic v);
    repeat (2) @(posedge clk_i);
    check("int enable", {31'h0, int_oe_o}, {31'h0, oe});
    check("int level", {31'h0, int_o}, {31'h0, v});
  endtask

  // ====
  // Main sequence.
  initial begin
    seed = 43;
    phy_a <= 5'($random(seed)) | 5'h01;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb_rd(8'h7c, 32'h00000001);
    int_chk(1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      idx = (i == 0) ? 5'h00 : ((i == 1) ? 5'h1e : (5'($random(seed)) & 5'h0f));
      d = 16'($random(seed));
      mw(phy_a, idx, d);
      wb_rd({1'b0, idx, 2'b00}, {16'h0000, d});
      mr(phy_a, idx, {16'h0000, d});
    end
    wb_rd(8'h80, 32'h00000003);
    wb(1'b1, 8'h80, 32'h00000003);
    mw(phy_a ^ 5'h02, 5'h10, 16'hbeef);
    wb_rd(8'h40, 32'h00000000);
    mr(phy_a ^ 5'h02, 5'h10, 32'h0001ffff);
    wb_rd(8'h80, 32'h00000004);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    wb(1'b1, 8'h84, 32'h00000004);
    check("irq", {31'h0, irq_o}, 32'h1);
    wb(1'b1, 8'h80, 32'h00000004);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    mw(5'h00, 5'h11, 16'h1234);
    wb_rd(8'h44, 32'h00001234);
    wb(1'b1, 8'h7c, 32'h00000000);
    mw(5'h00, 5'h12, 16'h5678);
    wb_rd(8'h48, 32'h00000000);
    evt(3);
    int_chk(1'b0, 1'b0);
    mr(phy_a, 5'h1c, 32'h00000008);
    mr(phy_a, 5'h1c, 32'h00000000);
    summary_i <= 1'b1;
    mr(phy_a, 5'h1c, 32'h00008000);
    mr(phy_a, 5'h1c, 32'h00008000);
    summary_i <= 1'b0;
    mw(phy_a, 5'h1b, 16'h0010);
    evt(4);
    int_chk(1'b1, 1'b0);
    wb(1'b1, 8'h7c, 32'h00000008);
    int_chk(1'b1, 1'b0);
    wb(1'b1, 8'h7c, 32'h0000000c);
    int_chk(1'b1, 1'b1);
    wb(1'b1, 8'h7c, 32'h00000004);
    int_chk(1'b1, 1'b0);
    mr(phy_a, 5'h1c, 32'h00000010);
    int_chk(1'b1, 1'b1);
    check("open drain", {31'h0, pp_seen}, 32'h0);
    wb(1'b1, 8'h7c, 32'h00000002);
    wb(1'b1, 8'h00, 32'h0000a5a5);
    mr(phy_a, 5'h00, 32'h0000a5a5);
    check("push pull", {31'h0, pp_seen}, 32'h1);
    bstrap <= 1'b0;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb_rd(8'h7c, 32'h00000000);
    repeat (2) @(posedge clk_i);
    final_report;
  end
endmodule
